/* logic/dsadc_defines.svh */
`ifndef DSADC_DEFINES_SVH
`define DSADC_DEFINES_SVH

// Clock and nominal output rate
`define DSADC_CLK_HZ 100000000
`define DSADC_RATE_SPS 192000
// Modulator bits per decimator sample, derived count
`define DSADC_RATIO_RST (`DSADC_CLK_HZ / `DSADC_RATE_SPS)
`define DSADC_RES_BITS 12
`define DSADC_PIPE_TAPS 4
`define DSADC_AVG_RST 8'h04

// Register byte offsets
`define DSADC_OFS_CTRL 8'h00
`define DSADC_OFS_CFG 8'h04
`define DSADC_OFS_MUX 8'h08
`define DSADC_OFS_STAT 8'h0C
`define DSADC_OFS_RES 8'h10

// Field positions
`define DSADC_CTRL_START 0
`define DSADC_CTRL_STOP 1
`define DSADC_CTRL_MODE 2
`define DSADC_CFG_AVG 16
`define DSADC_STAT_DONE 0
`define DSADC_STAT_BUSY 1
`define DSADC_STAT_VALID 2
`define DSADC_STAT_STATE 4
`define DSADC_STAT_LEVEL 8

// Reset values
`define DSADC_MODE_RST 2'h0
`define DSADC_MUX_RST 4'h0

`endif

/* logic/dsadc_pkg.sv */
package dsadc_pkg;

    // Operating modes
    typedef enum logic [1:0] {
        DSADC_SINGLE = 2'h0,
        DSADC_CONT = 2'h1,
        DSADC_FILT = 2'h2,
        DSADC_AVG = 2'h3
    } dsadc_mode_t;

    // Gray coded control states
    typedef enum logic [1:0] {
        DSADC_IDLE = 2'h0,
        DSADC_RST = 2'h1,
        DSADC_CONV = 2'h3,
        DSADC_WAIT = 2'h2
    } dsadc_state_t;

endpackage

/* logic/dsadc_fifo.sv */
module dsadc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH):0] count_o
);
    localparam int AW = $clog2(DEPTH);

    // Depth must be a power of two for pointer wrap
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("dsadc_fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // Handshakes with honest full and empty
    assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_ready_i && out_valid_o;
    assign out_data_o = mem_q[rd_q];
    assign count_o = cnt_q;

    // Storage
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    // Pointers and level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // dsadc_fifo

/* logic/dsadc_ctrl.sv */
// Implementation choices: the address map and register access over Wishbone.
`include "dsadc_defines.svh"

module dsadc_ctrl #(
    parameter int DEC_W = 16,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic mod_bit_i,
    input wire logic trig_i,
    output logic mod_reset_o,
    output logic [3:0] mux_sel_o,
    output dsadc_pkg::dsadc_mode_t mode_o,
    output logic done_o
);
    import dsadc_pkg::*;

    localparam int TAPS = `DSADC_PIPE_TAPS;
    localparam int SUM_W = DEC_W + 2;
    localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;

    // Ratio counter and result path need room
    if (DEC_W < 12 || DEC_W > 24) begin : g_chk
        $error("dsadc_ctrl DEC_W out of range");
    end

    // Pin synchronisers
    logic mod_s1_q;
    logic mod_s2_q;
    logic trig_s1_q;
    logic trig_s2_q;
    logic trig_s3_q;

    // Control and configuration
    dsadc_state_t state_q;
    logic [DEC_W-1:0] ratio_q;
    logic [7:0] avg_n_q;
    logic start_q;
    logic stop_q;
    logic mux_wr_q;

    // Decimator
    logic [DEC_W-1:0] cnt_q;
    logic [DEC_W-1:0] ones_q;
    logic [DEC_W-1:0] hist_q [TAPS];
    logic [2:0] fill_q;
    logic [31:0] avg_acc_q;
    logic [7:0] avg_cnt_q;

    // Result hand-off
    logic pend_q;
    logic [31:0] res_q;
    logic done_q;

    // Bus slave
    logic req;
    logic wr;
    logic rd;
    logic pop;

    // FIFO signals
    logic fifo_ready;
    logic fifo_valid;
    logic [31:0] fifo_data;
    logic [LVL_W-1:0] fifo_lvl;

    // Decimator decode
    logic stall;
    logic run;
    logic tick;
    logic full;
    logic [DEC_W-1:0] sample;
    logic [SUM_W-1:0] sum4;
    logic go;
    logic push;
    logic due;
    logic [31:0] stat;

    // Two flip-flops on both pins, edge from the third
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mod_s1_q <= 1'b0;
            mod_s2_q <= 1'b0;
            trig_s1_q <= 1'b0;
            trig_s2_q <= 1'b0;
            trig_s3_q <= 1'b0;
        end else begin
            mod_s1_q <= mod_bit_i;
            mod_s2_q <= mod_s1_q;
            trig_s1_q <= trig_i;
            trig_s2_q <= trig_s1_q;
            trig_s3_q <= trig_s2_q;
        end
    end

    // Bus strobes, one access per ack
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i;
    assign rd = req && !wb_we_i;
    assign pop = rd && (wb_adr_i == `DSADC_OFS_RES) && fifo_valid;

    // Start on either source; trigger counts only on its rising edge
    assign go = start_q || (trig_s2_q && !trig_s3_q);

    // Decimator runs in conversion unless a finished word is stuck
    assign stall = pend_q && !fifo_ready;
    assign run = (state_q == DSADC_CONV) && !stall;
    assign tick = run && (cnt_q == ratio_q - 1'b1);
    assign full = (fill_q == 3'(TAPS));
    assign push = pend_q && fifo_ready;

    // Ones count of the period closing now
    assign sample = ones_q + DEC_W'(mod_s2_q);

    // Four tap sum over the newest samples
    always_comb begin
        sum4 = SUM_W'(sample);
        for (int i = 0; i < TAPS - 1; i++) begin
            sum4 = sum4 + SUM_W'(hist_q[i]);
        end
    end

    // A result is due once the pipeline holds four fresh samples
    assign due = tick && (fill_q >= 3'(TAPS - 1)) && !mux_wr_q;

    // Ack and read data, one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (rd) begin
                unique case (wb_adr_i)
                    `DSADC_OFS_CTRL: wb_dat_o <= {28'h000_0000, mode_o, 2'h0};
                    `DSADC_OFS_CFG: wb_dat_o <= {8'h00, avg_n_q, 16'(ratio_q)};
                    `DSADC_OFS_MUX: wb_dat_o <= {28'h000_0000, mux_sel_o};
                    `DSADC_OFS_STAT: wb_dat_o <= stat;
                    `DSADC_OFS_RES: wb_dat_o <= fifo_valid ? fifo_data : 32'h0000_0000;
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Status word
    always_comb begin
        stat = 32'h0000_0000;
        stat[`DSADC_STAT_DONE] = done_q;
        stat[`DSADC_STAT_BUSY] = (state_q != DSADC_IDLE);
        stat[`DSADC_STAT_VALID] = full;
        stat[`DSADC_STAT_STATE +: 2] = state_q;
        stat[`DSADC_STAT_LEVEL +: LVL_W] = fifo_lvl;
    end

    // Control register writes; start and stop are one-cycle strobes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_o <= dsadc_mode_t'(`DSADC_MODE_RST);
            start_q <= 1'b0;
            stop_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            stop_q <= 1'b0;
            if (wr && wb_adr_i == `DSADC_OFS_CTRL && wb_sel_i[0]) begin
                start_q <= wb_dat_i[`DSADC_CTRL_START];
                stop_q <= wb_dat_i[`DSADC_CTRL_STOP];
                mode_o <= dsadc_mode_t'(wb_dat_i[`DSADC_CTRL_MODE +: 2]);
            end
        end
    end

    // Decimation ratio and averaging length; zero is held off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ratio_q <= DEC_W'(`DSADC_RATIO_RST);
            avg_n_q <= `DSADC_AVG_RST;
        end else if (wr && wb_adr_i == `DSADC_OFS_CFG) begin
            if (wb_sel_i[1:0] == 2'h3 && wb_dat_i[DEC_W-1:0] != '0) begin
                ratio_q <= wb_dat_i[DEC_W-1:0];
            end
            if (wb_sel_i[2] && wb_dat_i[`DSADC_CFG_AVG +: 8] != 8'h00) begin
                avg_n_q <= wb_dat_i[`DSADC_CFG_AVG +: 8];
            end
        end
    end

    // Input select; a write flags the pipeline stale
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mux_sel_o <= `DSADC_MUX_RST;
            mux_wr_q <= 1'b0;
        end else begin
            mux_wr_q <= 1'b0;
            if (wr && wb_adr_i == `DSADC_OFS_MUX && wb_sel_i[0]) begin
                mux_sel_o <= wb_dat_i[3:0];
                mux_wr_q <= 1'b1;
            end
        end
    end

    // Conversion sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= DSADC_IDLE;
        end else if (stop_q) begin
            state_q <= DSADC_IDLE;
        end else begin
            unique case (state_q)
                DSADC_IDLE: begin
                    if (go) begin
                        state_q <= DSADC_RST;
                    end
                end
                DSADC_RST: begin
                    state_q <= DSADC_CONV;
                end
                DSADC_CONV: begin
                    if (due && mode_o == DSADC_SINGLE) begin
                        state_q <= DSADC_WAIT;
                    end else if (due && mode_o == DSADC_FILT) begin
                        state_q <= DSADC_RST;
                    end
                end
                DSADC_WAIT: begin
                    if (!pend_q && !done_q) begin
                        state_q <= DSADC_IDLE;
                    end
                end
            endcase
        end
    end

    // Channel reset pulse, once per start or per filtered sample
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mod_reset_o <= 1'b0;
        end else begin
            mod_reset_o <= (state_q == DSADC_IDLE && go && !stop_q)
                || (state_q == DSADC_CONV && due && mode_o == DSADC_FILT && !stop_q);
        end
    end

    // Period counter and ones accumulator
    always_ff @(posedge clk_i) begin
        if (rst_i || state_q != DSADC_CONV) begin
            cnt_q <= '0;
            ones_q <= '0;
        end else if (tick) begin
            cnt_q <= '0;
            ones_q <= '0;
        end else if (run) begin
            cnt_q <= cnt_q + 1'b1;
            ones_q <= sample;
        end
    end

    // Sample history, newest first
    for (genvar g = 0; g < TAPS; g++) begin : g_hist
        always_ff @(posedge clk_i) begin
            if (rst_i || state_q == DSADC_RST) begin
                hist_q[g] <= '0;
            end else if (tick) begin
                hist_q[g] <= (g == 0) ? sample : hist_q[(g == 0) ? 0 : g - 1];
            end
        end
    end

    // Valid sample count since reset or input switch
    always_ff @(posedge clk_i) begin
        if (rst_i || state_q == DSADC_RST || mux_wr_q) begin
            fill_q <= 3'h0;
        end else if (tick && !full) begin
            fill_q <= fill_q + 1'b1;
        end
    end

    // First order sinc post stage for the average mode
    always_ff @(posedge clk_i) begin
        if (rst_i || state_q == DSADC_IDLE || mode_o != DSADC_AVG) begin
            avg_acc_q <= 32'h0000_0000;
            avg_cnt_q <= 8'h00;
        end else if (due) begin
            if (avg_cnt_q == avg_n_q - 1'b1) begin
                avg_acc_q <= 32'h0000_0000;
                avg_cnt_q <= 8'h00;
            end else begin
                avg_acc_q <= avg_acc_q + 32'(sum4);
                avg_cnt_q <= avg_cnt_q + 1'b1;
            end
        end
    end

    // Finished word waits for the FIFO; a push never repeats a word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_q <= 1'b0;
            res_q <= 32'h0000_0000;
        end else begin
            if (push) begin
                pend_q <= 1'b0;
            end
            if (due && mode_o != DSADC_AVG) begin
                pend_q <= 1'b1;
                res_q <= 32'(sum4);
            end else if (due && avg_cnt_q == avg_n_q - 1'b1) begin
                pend_q <= 1'b1;
                res_q <= avg_acc_q + 32'(sum4);
            end
        end
    end

    // Done flag: set by a stored result, cleared by reading the last one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_q <= 1'b0;
        end else if (push) begin
            done_q <= 1'b1;
        end else if (pop && fifo_lvl == LVL_W'(1)) begin
            done_q <= 1'b0;
        end
    end

    // Done pin is the status flag register itself
    assign done_o = done_q;

    // Result queue toward the CPU or DMA reader
    dsadc_fifo #(
        .WIDTH(32),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(pend_q),
        .in_ready_o(fifo_ready),
        .in_data_i(res_q),
        .out_valid_o(fifo_valid),
        .out_ready_i(pop),
        .out_data_o(fifo_data),
        .count_o(fifo_lvl)
    );

endmodule // dsadc_ctrl

/* tb/dsadc_ctrl_properties.sv */
module dsadc_ctrl_properties
    import dsadc_pkg::*;
#(
    parameter int DEC_W = 16,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic mod_bit_i,
    input wire logic trig_i,
    input wire logic mod_reset_o,
    input wire logic [3:0] mux_sel_o,
    input wire dsadc_pkg::dsadc_mode_t mode_o,
    input wire logic done_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic rd_req, mux_wr, ctrl_wr, trig_q;
    logic [7:0] mux_age_q, start_age_q;
    logic [1:0] single_cnt_q;
    // Bus requests of interest
    assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i == 8'h10;
    assign mux_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h08;
    assign ctrl_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h00;
    // Age since last select write
    always_ff @(posedge clk_i) begin
        if (rst_i || mux_wr) mux_age_q <= 8'h00;
        else if (mux_age_q != 8'hFF) mux_age_q <= mux_age_q + 8'h01;
    end
    // Age since last start cause
    always_ff @(posedge clk_i) begin
        trig_q <= trig_i;
        if (rst_i || ctrl_wr || (trig_i && !trig_q)) start_age_q <= 8'h00;
        else if (start_age_q != 8'hFF) start_age_q <= start_age_q + 8'h01;
    end
    // Channel resets while trigger held in single mode
    always_ff @(posedge clk_i) begin
        if (rst_i || !trig_i || ctrl_wr) single_cnt_q <= 2'h0;
        else if (mod_reset_o && mode_o == DSADC_SINGLE && single_cnt_q != 2'h3) single_cnt_q <= single_cnt_q + 2'h1;
    end
    sequence s_unread;
        (done_o && !rd_req) ##1 !rd_req;
    endsequence
    a_done_hold: assert property (s_unread |=> done_o)
        else $error("done dropped without a result read");
    a_done_fall: assert property ($fell(done_o) |-> $past(rd_req) || $past(rd_req, 2))
        else $error("done fell with no result read");
    a_reset_pulse: assert property (mod_reset_o |=> !mod_reset_o)
        else $error("channel reset longer than one cycle");
    a_mux_cause: assert property ($changed(mux_sel_o) |-> $past(mux_wr))
        else $error("input select changed without a write");
    a_mux_settle: assert property ($rose(done_o) |-> mux_age_q >= 8'h04)
        else $error("result too soon after select change");
    a_mode_cause: assert property ($changed(mode_o) |-> $past(ctrl_wr))
        else $error("mode changed without a control write");
    a_trig_once: assert property (mod_reset_o && mode_o == DSADC_SINGLE && trig_i |-> single_cnt_q == 2'h0)
        else $error("held trigger started a second conversion");
    a_cont_reset: assert property (mod_reset_o && (mode_o == DSADC_CONT || mode_o == DSADC_AVG) |-> start_age_q <= 8'h08)
        else $error("channel reset in mid run");
    a_conv_span: assert property (mod_reset_o && !done_o && mode_o == DSADC_SINGLE |=> !done_o [*3])
        else $error("result before four samples");
endmodule // dsadc_ctrl_properties

bind dsadc_ctrl dsadc_ctrl_properties #(.DEC_W(DEC_W), .FIFO_DEPTH(FIFO_DEPTH)) u_props (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .mod_bit_i(mod_bit_i), .trig_i(trig_i), .mod_reset_o(mod_reset_o), .mux_sel_o(mux_sel_o),
    .mode_o(mode_o), .done_o(done_o));

/* tb/dsadc_mod_model.sv */
module dsadc_mod_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] pattern_i,
    input wire logic [1:0] trig_mode_i,
    output logic mod_bit_o,
    output logic trig_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tog_q;
    logic [5:0] div_q;
    // Free running toggle and trigger clock divider
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tog_q <= 1'h0;
            div_q <= 6'h00;
        end else begin
            tog_q <= ~tog_q;
            div_q <= div_q + 6'h01;
        end
    end
    // Bitstream: zeros, all ones or half density
    assign mod_bit_o = (pattern_i == 2'h1) ? 1'h1 : (pattern_i == 2'h2) ? tog_q : 1'h0;
    // Trigger: idle low, held high, or a digital clock
    assign trig_o = (trig_mode_i == 2'h1) ? 1'h1 : (trig_mode_i == 2'h2) ? div_q[5] : 1'h0;
endmodule // dsadc_mod_model

/* tb/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import dsadc_pkg::*;
    localparam int RATIO = 4;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic cyc = 1'h0, stb = 1'h0, we = 1'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, wb_rdat;
    logic [1:0] pattern = 2'h1, trig_mode = 2'h0;
    logic wb_ack, mod_bit, trig, mod_rst, done;
    logic [3:0] mux_sel;
    dsadc_mode_t mode;
    int errors = 0, checks_done = 0, resets_seen = 0;
    // System clock
    always #5 clk_i = ~clk_i;
    // Count channel reset pulses away from the sampling edge
    always @(negedge clk_i) begin
        if (mod_rst === 1'h1) resets_seen++;
    end
    dsadc_ctrl #(.DEC_W(16), .FIFO_DEPTH(16)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .mod_bit_i(mod_bit), .trig_i(trig), .mod_reset_o(mod_rst), .mux_sel_o(mux_sel), .mode_o(mode), .done_o(done));
    dsadc_mod_model u_model (.clk_i(clk_i), .rst_i(rst_i), .pattern_i(pattern), .trig_mode_i(trig_mode),
        .mod_bit_o(mod_bit), .trig_o(trig));
    task automatic finish_test();
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    // Classic single Wishbone access, entered just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'h1 && n < 50);
        rdat = wb_rdat;
        if (n >= 50) check(32'h0, 32'h1, "bus timeout");
        cyc <= 1'h0;
        stb <= 1'h0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
        bus(1'h0, a, 32'h0);
        check(rdat, e, what);
    endtask
    task automatic wait_done(output int n);
        n = 0;
        while (done !== 1'h1 && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 400) check(32'h0, 32'h1, "done timeout");
    endtask
    task automatic drain(input logic [31:0] e, output int n);
        n = 0;
        while (done === 1'h1 && n < 20) begin
            rd(8'h10, e, "drained result");
            @(posedge clk_i);
            @(posedge clk_i);
            n++;
        end
    endtask
    task automatic t_reset();
        logic [7:0] adrs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h40};
        logic [31:0] exps [6] = '{32'h0, 32'h0004_0208, 32'h0, 32'h0, 32'h0, 32'h0};
        bus(1'h1, 8'h0C, 32'hFFFF_FFFF);
        bus(1'h1, 8'h40, 32'hFFFF_FFFF);
        bus(1'h1, 8'h04, 32'h0000_0000);
        for (int i = 0; i < 6; i++) begin
            rd(adrs[i], exps[i], "reset value");
        end
        check({31'h0, done}, 32'h0, "done after reset");
    endtask
    task automatic t_single();
        int n, r0;
        bus(1'h1, 8'h04, 32'h0004_0004);
        rd(8'h04, 32'h0004_0004, "config");
        r0 = resets_seen;
        bus(1'h1, 8'h00, 32'h0000_0001);
        wait_done(n);
        bus(1'h0, 8'h0C, 32'h0);
        check({26'h0, rdat[12:8], rdat[0]}, 32'h3, "status done");
        repeat (20) @(posedge clk_i);
        check({31'h0, done}, 32'h1, "done held");
        rd(8'h10, 32'(4 * RATIO), "single result");
        repeat (100) @(posedge clk_i);
        check({31'h0, done}, 32'h0, "standby");
        bus(1'h0, 8'h0C, 32'h0);
        check({30'h0, rdat[5:4]}, 32'h0, "standby state");
        check(32'(resets_seen - r0), 32'h1, "one conversion");
    endtask
    task automatic t_mux();
        int n;
        bus(1'h1, 8'h00, 32'h0000_0001);
        bus(1'h1, 8'h08, 32'h0000_0005);
        check({28'h0, mux_sel}, 32'h5, "select");
        wait_done(n);
        check({31'h0, n >= 3 * RATIO}, 32'h1, "settle time");
        rd(8'h10, 32'(4 * RATIO), "result after select");
        bus(1'h1, 8'h08, 32'h0);
    endtask
    task automatic t_trig();
        int n, r0;
        r0 = resets_seen;
        trig_mode <= 2'h1;
        wait_done(n);
        rd(8'h10, 32'(4 * RATIO), "trigger result");
        repeat (100) @(posedge clk_i);
        check({31'h0, done}, 32'h0, "held trigger");
        check(32'(resets_seen - r0), 32'h1, "held trigger starts");
        trig_mode <= 2'h0;
        repeat (40) @(posedge clk_i);
        trig_mode <= 2'h2;
        for (int i = 0; i < 2; i++) begin
            wait_done(n);
            rd(8'h10, 32'(4 * RATIO), "clocked trigger");
        end
        trig_mode <= 2'h0;
        repeat (100) @(posedge clk_i);
        drain(32'(4 * RATIO), n);
    endtask
    task automatic t_cont();
        int n, r0;
        r0 = resets_seen;
        bus(1'h1, 8'h00, 32'h0000_0005);
        check({30'h0, mode}, 32'h1, "continuous mode");
        repeat (200) @(posedge clk_i);
        bus(1'h0, 8'h0C, 32'h0);
        check({27'h0, rdat[12:8]}, 32'h0000_0010, "buffer full");
        check(32'(resets_seen - r0), 32'h1, "single reset");
        bus(1'h1, 8'h00, 32'h0000_0006);
        drain(32'(4 * RATIO), n);
        check({31'h0, n >= 16}, 32'h1, "drained count");
        check({31'h0, done}, 32'h0, "drained done");
    endtask
    task automatic t_filt();
        int n, r0;
        pattern <= 2'h2;
        r0 = resets_seen;
        bus(1'h1, 8'h00, 32'h0000_0009);
        repeat (150) @(posedge clk_i);
        bus(1'h1, 8'h00, 32'h0000_000A);
        check({31'h0, resets_seen - r0 > 2}, 32'h1, "resets between");
        drain(32'(2 * RATIO), n);
        check({31'h0, n >= 2}, 32'h1, "back to back");
    endtask
    task automatic t_avg();
        int n, r0;
        pattern <= 2'h1;
        r0 = resets_seen;
        bus(1'h1, 8'h00, 32'h0000_000D);
        check({30'h0, mode}, 32'h3, "average mode");
        repeat (200) @(posedge clk_i);
        bus(1'h1, 8'h00, 32'h0000_000E);
        check(32'(resets_seen - r0), 32'h1, "no modulator reset");
        drain(32'(16 * RATIO), n);
        check({31'h0, n >= 2}, 32'h1, "average words");
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        t_reset();
        t_single();
        t_mux();
        t_trig();
        t_cont();
        t_filt();
        t_avg();
        finish_test();
    end
    // Watchdog
    initial begin
        repeat (30000) @(posedge clk_i);
        errors++;
        finish_test();
    end
endmodule // testbench
